/* File: ddpsr_regs.sv */
// Stack pointer, primary and auxiliary data pointers and bank select.
// Assumes the core drives one request per clock, same clock domain.
//
// Summary of operation
// - Stack pointer increments before each push or call byte is stored.
// - Stack pointer decrements after each pop, return or interrupt-return byte.
// - Reset loads stack pointer with 07h.
// - Stack pointer is an 8-bit readable and writable register.
// - Primary data pointer is 16 bits in separate low and high byte registers.
// - Auxiliary 16-bit data pointer, own low and high bytes, independent.
// - Select bit 0 routes pointer instructions to primary (0) or auxiliary (1).
// - With auxiliary selected, pointer loads and increments touch only auxiliary.
`timescale 1ns/1ps
`include "ddpsr_map.svh"

module ddpsr_regs
  import ddpsr_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire ddpsr_sfr_req_s sfr_req,
  input wire ddpsr_core_req_s core_req,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  output logic [7:0] stack_write_addr,
  output logic [7:0] stack_top_pointer,
  output logic [15:0] active_data_pointer,
  output logic pointer_bank_select
);

  // Byte registers behind the two pointer pairs
  logic [7:0] primary_ptr_low_byte;
  logic [7:0] primary_ptr_high_byte;
  logic [7:0] aux_ptr_low_byte;
  logic [7:0] aux_ptr_high_byte;

  // Next values, one set per group of state
  logic [7:0] next_stack_top_pointer;
  logic [7:0] next_stack_write_addr;
  logic [7:0] next_primary_ptr_low_byte;
  logic [7:0] next_primary_ptr_high_byte;
  logic [7:0] next_aux_ptr_low_byte;
  logic [7:0] next_aux_ptr_high_byte;
  logic next_pointer_bank_select;
  logic [15:0] next_active_data_pointer;
  logic [7:0] next_sfr_rdata;

  // Whole pair words as the core sees them
  logic [15:0] pri_word;
  logic [15:0] aux_word;

  // Per-register write strobes and bank steering
  localparam int unsigned REG_COUNT = 6;
  logic [REG_COUNT-1:0] wr_strobe;
  logic wr_stack;
  logic wr_pri_lo;
  logic wr_pri_hi;
  logic wr_aux_lo;
  logic wr_aux_hi;
  logic wr_select;
  logic pri_takes_op;
  logic aux_takes_op;

  // Decode used by the write strobes only; the read path and sfr_hit decode on their own
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] target);
    addr_is = (a == target);
  endfunction : addr_is

  // Pointer update for one bank; unselected banks pass through unchanged
  function automatic logic [15:0] dp_update(input logic [15:0] cur, input ddpsr_dp_e op,
                                            input logic [15:0] ld);
    case (op)
      DDPSR_DP_LOAD: dp_update = ld;
      DDPSR_DP_INC: dp_update = cur + 16'h0001;
      default: dp_update = cur;
    endcase
  endfunction : dp_update

  // Stack pointer movement for one core request; other codes leave it alone
  function automatic logic [7:0] stk_update(input logic [7:0] cur, input ddpsr_stk_e op);
    case (op)
      DDPSR_STK_PUSH: stk_update = cur + 8'h01;
      DDPSR_STK_POP: stk_update = cur - 8'h01;
      default: stk_update = cur;
    endcase
  endfunction : stk_update

  assign pri_word = {primary_ptr_high_byte, primary_ptr_low_byte};
  assign aux_word = {aux_ptr_high_byte, aux_ptr_low_byte};

  // One strobe per mapped register, in address order from the stack pointer up.
  // This relies on the six registers sitting at consecutive addresses.
  genvar reg_idx;
  generate
    for (reg_idx = 0; reg_idx < REG_COUNT; reg_idx++) begin : g_wr_strobe
      assign wr_strobe[reg_idx] = sfr_req.wr_en
        && addr_is(sfr_req.addr, `DDPSR_ADDR_STACK + 8'(reg_idx));
    end
  endgenerate

  assign wr_stack = wr_strobe[0];
  assign wr_pri_lo = wr_strobe[1];
  assign wr_pri_hi = wr_strobe[2];
  assign wr_aux_lo = wr_strobe[3];
  assign wr_aux_hi = wr_strobe[4];
  assign wr_select = wr_strobe[5];

  // core pointer ops reach only the selected bank
  assign pri_takes_op = !pointer_bank_select;
  assign aux_takes_op = pointer_bank_select;

  // Address range decode, independent of the strobes
  assign sfr_hit = sfr_req.addr inside {`DDPSR_ADDR_STACK, `DDPSR_ADDR_PRI_LO,
                                        `DDPSR_ADDR_PRI_HI, `DDPSR_ADDR_AUX_LO,
                                        `DDPSR_ADDR_AUX_HI, `DDPSR_ADDR_SELECT};

  // Stack group: pointer and push target move together.
  // The pointer wraps modulo 256; there is no overflow or underflow flag.
  always_comb begin
    next_stack_top_pointer = stk_update(stack_top_pointer, core_req.stk_op);
    // writable stack pointer; software wins over a same-cycle core move
    if (wr_stack) begin
      next_stack_top_pointer = sfr_req.wdata;
    end
    // push target registered one above the new top
    next_stack_write_addr = next_stack_top_pointer + 8'h01;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stack_top_pointer <= `DDPSR_RST_STACK;
      stack_write_addr <= `DDPSR_RST_STACK + 8'h01;
    end else begin
      stack_top_pointer <= next_stack_top_pointer;
      stack_write_addr <= next_stack_write_addr;
    end
  end

  // Primary pair group
  always_comb begin
    logic [15:0] pri_new;
    pri_new = pri_word;
    // primary pair moves only while it is the selected bank
    if (pri_takes_op) begin
      pri_new = dp_update(pri_word, core_req.dp_op, core_req.dp_load);
    end
    next_primary_ptr_low_byte = pri_new[7:0];
    next_primary_ptr_high_byte = pri_new[15:8];
    // a byte write replaces its own byte; the other keeps the core result
    if (wr_pri_lo) begin
      next_primary_ptr_low_byte = sfr_req.wdata;
    end
    if (wr_pri_hi) begin
      next_primary_ptr_high_byte = sfr_req.wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      primary_ptr_low_byte <= `DDPSR_RST_PTR_BYTE;
      primary_ptr_high_byte <= `DDPSR_RST_PTR_BYTE;
    end else begin
      primary_ptr_low_byte <= next_primary_ptr_low_byte;
      primary_ptr_high_byte <= next_primary_ptr_high_byte;
    end
  end

  // Auxiliary pair group, a copy of the primary one with its own steering
  always_comb begin
    logic [15:0] aux_new;
    aux_new = aux_word;
    // auxiliary pair moves only while it is the selected bank
    if (aux_takes_op) begin
      aux_new = dp_update(aux_word, core_req.dp_op, core_req.dp_load);
    end
    next_aux_ptr_low_byte = aux_new[7:0];
    next_aux_ptr_high_byte = aux_new[15:8];
    // auxiliary byte writes, independent of the primary pair
    if (wr_aux_lo) begin
      next_aux_ptr_low_byte = sfr_req.wdata;
    end
    if (wr_aux_hi) begin
      next_aux_ptr_high_byte = sfr_req.wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      aux_ptr_low_byte <= `DDPSR_RST_PTR_BYTE;
      aux_ptr_high_byte <= `DDPSR_RST_PTR_BYTE;
    end else begin
      aux_ptr_low_byte <= next_aux_ptr_low_byte;
      aux_ptr_high_byte <= next_aux_ptr_high_byte;
    end
  end

  // Bank select group
  always_comb begin
    next_pointer_bank_select = pointer_bank_select;
    // only bit 0 stored, the upper bits are dropped
    if (wr_select) begin
      next_pointer_bank_select = sfr_req.wdata[`DDPSR_SEL_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      // select resets to the primary bank
      pointer_bank_select <= `DDPSR_RST_SELECT;
    end else begin
      pointer_bank_select <= next_pointer_bank_select;
    end
  end

  // Active pointer group: registered from next values, so it never lags
  // the pair it mirrors, while the output still comes straight from a flop.
  always_comb begin
    if (next_pointer_bank_select) begin
      next_active_data_pointer = {next_aux_ptr_high_byte, next_aux_ptr_low_byte};
    end else begin
      next_active_data_pointer = {next_primary_ptr_high_byte, next_primary_ptr_low_byte};
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      active_data_pointer <= {`DDPSR_RST_PTR_BYTE, `DDPSR_RST_PTR_BYTE};
    end else begin
      active_data_pointer <= next_active_data_pointer;
    end
  end

  // Read group: a read in the same cycle as a write returns the old value

  always_comb begin
    next_sfr_rdata = 8'h00;
    if (sfr_req.rd_en) begin
      case (sfr_req.addr)
        `DDPSR_ADDR_STACK: next_sfr_rdata = stack_top_pointer;
        `DDPSR_ADDR_PRI_LO: next_sfr_rdata = primary_ptr_low_byte;
        `DDPSR_ADDR_PRI_HI: next_sfr_rdata = primary_ptr_high_byte;
        `DDPSR_ADDR_AUX_LO: next_sfr_rdata = aux_ptr_low_byte;
        `DDPSR_ADDR_AUX_HI: next_sfr_rdata = aux_ptr_high_byte;
        `DDPSR_ADDR_SELECT: next_sfr_rdata = {7'h00, pointer_bank_select};
        default: next_sfr_rdata = 8'h00;
      endcase
    end
  end

  // Read data stands one cycle and falls back to zero when no read is made
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sfr_rdata <= 8'h00;
    end else begin
      sfr_rdata <= next_sfr_rdata;
    end
  end

endmodule : ddpsr_regs

/* File: ddpsr_map.svh */
// Special-function register offsets, field positions and reset values
// for the stack pointer and dual data pointer block.
// Assumes an 8-bit special-function register address space.
`ifndef DDPSR_MAP_SVH
`define DDPSR_MAP_SVH

`define DDPSR_ADDR_STACK 8'h81
`define DDPSR_ADDR_PRI_LO 8'h82
`define DDPSR_ADDR_PRI_HI 8'h83
`define DDPSR_ADDR_AUX_LO 8'h84
`define DDPSR_ADDR_AUX_HI 8'h85
`define DDPSR_ADDR_SELECT 8'h86

`define DDPSR_RST_STACK 8'h07
`define DDPSR_RST_PTR_BYTE 8'h00
`define DDPSR_RST_SELECT 1'h0

`define DDPSR_SEL_BIT 0

`endif

/* File: ddpsr_pkg.sv */
// Types shared by the stack pointer and dual data pointer block.
// Assumes the constants of ddpsr_map.svh for addresses and reset values.
package ddpsr_pkg;

  // Stack operation requested by the core for this cycle
  typedef enum logic [3:0] {
    DDPSR_STK_NONE = 4'h1,
    DDPSR_STK_PUSH = 4'h2,
    DDPSR_STK_POP = 4'h4,
    DDPSR_STK_HOLD = 4'h8
  } ddpsr_stk_e;

  // Data pointer operation requested by the core for this cycle
  typedef enum logic [3:0] {
    DDPSR_DP_NONE = 4'h1,
    DDPSR_DP_LOAD = 4'h2,
    DDPSR_DP_INC = 4'h4,
    DDPSR_DP_HOLD = 4'h8
  } ddpsr_dp_e;

  // Register-space access from the core
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ddpsr_sfr_req_s;

  // Core request for pointer movement
  typedef struct packed {
    ddpsr_stk_e stk_op;
    ddpsr_dp_e dp_op;
    logic [15:0] dp_load;
  } ddpsr_core_req_s;

endpackage : ddpsr_pkg

/* File: ddpsr_regs_asserts.sv */
// Checker for the stack and dual data pointer registers.
// Assumes it sees only the ports of ddpsr_regs, one clock, synchronous reset.
`timescale 1ns/1ps
module ddpsr_chk
  import ddpsr_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire ddpsr_sfr_req_s sfr_req,
  input wire ddpsr_core_req_s core_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_hit,
  input wire logic [7:0] stack_write_addr,
  input wire logic [7:0] stack_top_pointer,
  input wire logic [15:0] active_data_pointer,
  input wire logic pointer_bank_select
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Software writes win over core ops, so those cycles are left out
  wire sp_wr = sfr_req.wr_en && sfr_req.addr == 8'h81;
  wire dp_wr = sfr_req.wr_en && sfr_req.addr > 8'h81 && sfr_req.addr < 8'h87;
  push_inc_a: assert property (core_req.stk_op == DDPSR_STK_PUSH && !sp_wr
    |=> stack_top_pointer == $past(stack_top_pointer) + 8'h01)
    else $error("push did not raise stack pointer");
  push_addr_a: assert property (stack_write_addr == stack_top_pointer + 8'h01)
    else $error("push address not above stack pointer");
  pop_dec_a: assert property (core_req.stk_op == DDPSR_STK_POP && !sp_wr
    |=> stack_top_pointer == $past(stack_top_pointer) - 8'h01)
    else $error("pop did not lower stack pointer");
  stack_reset_a: assert property ($fell(sys_rst) |-> stack_top_pointer == 8'h07)
    else $error("stack pointer reset value wrong");
  stack_write_a: assert property (sp_wr |=> stack_top_pointer == $past(sfr_req.wdata))
    else $error("stack pointer write lost");
  dp_load_a: assert property (core_req.dp_op == DDPSR_DP_LOAD && !dp_wr
    |=> active_data_pointer == $past(core_req.dp_load))
    else $error("pointer load wrong");
  dp_inc_a: assert property (core_req.dp_op == DDPSR_DP_INC && !dp_wr
    |=> active_data_pointer == $past(active_data_pointer) + 16'h0001)
    else $error("pointer increment wrong");
  sel_write_a: assert property (sfr_req.wr_en && sfr_req.addr == 8'h86
    |=> pointer_bank_select == $past(sfr_req.wdata[0]))
    else $error("select write lost");
  sel_read_a: assert property (sfr_req.rd_en && sfr_req.addr == 8'h86
    |=> sfr_rdata == {7'h00, $past(pointer_bank_select)})
    else $error("select read wrong");
endmodule : ddpsr_chk

bind ddpsr_regs ddpsr_chk chk_u (.clock, .sys_rst, .sfr_req, .core_req, .sfr_rdata, .sfr_hit,
  .stack_write_addr, .stack_top_pointer, .active_data_pointer, .pointer_bank_select);

/* File: dual_data_pointer_stack_regs_tb_top.sv */
// Testbench for the stack and dual data pointer registers.
// Assumes ddpsr_regs alone, driven on its register and core ports.
`timescale 1ns/1ps
module dual_data_pointer_stack_regs_tb_top import ddpsr_pkg::*;;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  ddpsr_sfr_req_s sfr_req = '0;
  ddpsr_core_req_s core_req = '{DDPSR_STK_NONE, DDPSR_DP_NONE, 16'h0000};
  logic [7:0] sfr_rdata, stack_write_addr, stack_top_pointer;
  logic sfr_hit, pointer_bank_select;
  logic [15:0] active_data_pointer;
  int error_cnt = 0;
  int tests_run = 0;
  ddpsr_regs dut_u (.clock, .sys_rst, .sfr_req, .core_req, .sfr_rdata, .sfr_hit,
    .stack_write_addr, .stack_top_pointer, .active_data_pointer, .pointer_bank_select);
  initial forever #20 clock = ~clock;
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clock) sfr_req <= '{1'b1, 1'b0, a, d};
    @(posedge clock) sfr_req <= '0;
    #1;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clock) sfr_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clock) sfr_req <= '0;
    #1 chk("rdata", {8'h00, sfr_rdata}, {8'h00, e});
  endtask : rd
  task automatic op(ddpsr_stk_e s, ddpsr_dp_e p, logic [15:0] v);
    @(posedge clock) core_req <= '{s, p, v};
    @(posedge clock) core_req <= '{DDPSR_STK_NONE, DDPSR_DP_NONE, 16'h0000};
    #1;
  endtask : op
  task automatic conclude;
    if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  initial begin
    #20000;
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    for (int i = 1; i < 7; i++) rd(8'h80 + i[7:0], (i == 1) ? 8'h07 : 8'h00);
    chk("push addr", {8'h00, stack_write_addr}, 16'h0008);
    rd(8'h87, 8'h00);
    @(posedge clock) sfr_req.addr <= 8'h86;
    #1 chk("hit", {15'h0000, sfr_hit}, 16'h0001);
    @(posedge clock) sfr_req.addr <= 8'h87;
    #1 chk("hit", {15'h0000, sfr_hit}, 16'h0000);
    @(posedge clock) sfr_req <= '0;
    wr(8'h81, 8'hFF);
    rd(8'h81, 8'hFF);
    op(DDPSR_STK_PUSH, DDPSR_DP_NONE, 16'h0000);
    chk("stack", {8'h00, stack_top_pointer}, 16'h0000);
    chk("push addr", {8'h00, stack_write_addr}, 16'h0001);
    op(DDPSR_STK_POP, DDPSR_DP_NONE, 16'h0000);
    op(DDPSR_STK_POP, DDPSR_DP_NONE, 16'h0000);
    chk("stack", {8'h00, stack_top_pointer}, 16'h00FE);
    op(DDPSR_STK_NONE, DDPSR_DP_LOAD, 16'h12FF);
    op(DDPSR_STK_NONE, DDPSR_DP_INC, 16'h0000);
    chk("active_data_pointer", active_data_pointer, 16'h1300);
    wr(8'h86, 8'hFF);
    rd(8'h86, 8'h01);
    chk("active_data_pointer", active_data_pointer, 16'h0000);
    op(DDPSR_STK_NONE, DDPSR_DP_LOAD, 16'hFFFF);
    op(DDPSR_STK_NONE, DDPSR_DP_INC, 16'h0000);
    chk("active_data_pointer", active_data_pointer, 16'h0000);
    wr(8'h84, 8'hCD);
    chk("active_data_pointer", active_data_pointer, 16'h00CD);
    rd(8'h82, 8'h00);
    rd(8'h83, 8'h13);
    wr(8'h86, 8'h00);
    chk("active_data_pointer", active_data_pointer, 16'h1300);
    @(posedge clock) sys_rst <= 1'b1;
    @(posedge clock) sys_rst <= 1'b0;
    #1 chk("stack", {8'h00, stack_top_pointer}, 16'h0007);
    chk("active_data_pointer", active_data_pointer, 16'h0000);
    rd(8'h83, 8'h00);
    conclude();
  end
endmodule : dual_data_pointer_stack_regs_tb_top
